// file: hw/fcct_top.sv
`timescale 1ns/1ps
module fcct_top
	import fcct_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// host bus
	input wire logic chip_en_b_i,
	input wire logic iorq_b_i,
	input wire logic rd_b_i,
	input wire logic m1_b_i,
	input wire logic chan_sel_lo_i,
	input wire logic chan_sel_hi_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_o,
	// interrupt daisy chain
	input wire logic chain_enable_in_i,
	output logic chain_enable_out_o,
	output logic irq_b_o,
	output logic irq_oe_o,
	// channel pins
	input wire logic [NUM_CH-1:0] ext_count_trigger_i,
	output logic [NUM_ZC-1:0] zero_count_pulse_o
);

	// eligible requests: blocked at and below any channel in service
	function automatic logic [NUM_CH-1:0] eligible(input logic [NUM_CH-1:0] ip,
		input logic [NUM_CH-1:0] ius);
		logic blocked;
		logic [NUM_CH-1:0] r;
		blocked = 1'b0;
		r = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			blocked = blocked | ius[i];
			r[i] = ip[i] & ~blocked;
		end
		return r;
	endfunction

	// lowest index set wins
	function automatic logic [1:0] first_set(input logic [NUM_CH-1:0] v);
		logic [1:0] r;
		r = 2'd0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 2'(i);
			end
		end
		return r;
	endfunction

	fcct_pins_t pin_raw, pin_s1_q, pin_s2_q;
	logic [NUM_CH-1:0] trg_s1_q, trg_s2_q;
	logic iei_s1_q, iei_s2_q;
	logic io_wr, io_rd, ack, fetch;
	logic wr_prev_q, ack_prev_q, fetch_prev_q;
	logic wr_stb, ack_start, fetch_end, return_from_irq_opcode_ev;
	logic [NUM_CH-1:0] wr_ch;
	logic [NUM_CH-1:0] zero_vec;
	fcct_ch_stat_t ch_stat [NUM_CH];
	logic [7:0] op_q, op_d;
	logic prev_ed_q, prev_ed_d;
	logic [7:0] vec_q, vec_d;
	logic [NUM_CH-1:0] ip_q, ip_d;
	logic [NUM_CH-1:0] ius_q, ius_d;
	logic [NUM_CH-1:0] elig;
	logic [1:0] svc_q, svc_d;
	logic vec_drive_q, vec_drive_d;
	logic [7:0] data_d;
	logic data_oe_d, irq_oe_d, chain_out_d;

	always_comb begin
		pin_raw = '{iorq_b: iorq_b_i, rd_b: rd_b_i, m1_b: m1_b_i, ce_b: chip_en_b_i,
			sel: {chan_sel_hi_i, chan_sel_lo_i}, data: data_i};
	end

	// synchronisers run free so chain enable still passes through during reset
	always_ff @(posedge mclk_i) begin
		pin_s1_q <= pin_raw;
		pin_s2_q <= pin_s1_q;
		trg_s1_q <= ext_count_trigger_i;
		trg_s2_q <= trg_s1_q;
		iei_s1_q <= chain_enable_in_i;
		iei_s2_q <= iei_s1_q;
	end

	// bus cycle decode
	always_comb begin
		io_wr = !pin_s2_q.iorq_b && !pin_s2_q.ce_b && pin_s2_q.rd_b && pin_s2_q.m1_b;
		io_rd = !pin_s2_q.iorq_b && !pin_s2_q.ce_b && !pin_s2_q.rd_b && pin_s2_q.m1_b;
		ack = !pin_s2_q.iorq_b && !pin_s2_q.m1_b;
		fetch = pin_s2_q.iorq_b && !pin_s2_q.m1_b && !pin_s2_q.rd_b;
		wr_stb = io_wr && !wr_prev_q;
		ack_start = ack && !ack_prev_q;
		fetch_end = fetch_prev_q && !fetch;
		for (int i = 0; i < NUM_CH; i++) begin
			wr_ch[i] = wr_stb && (pin_s2_q.sel == 2'(i));
			zero_vec[i] = ch_stat[i].zero;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			wr_prev_q <= 1'b0;
			ack_prev_q <= 1'b0;
			fetch_prev_q <= 1'b0;
		end else begin
			wr_prev_q <= io_wr;
			ack_prev_q <= ack;
			fetch_prev_q <= fetch;
		end
	end

	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		fcct_channel u_ch (
			.mclk_i(mclk_i),
			.rst_b_i(rst_b_i),
			.wr_i(wr_ch[g]),
			.wdata_i(pin_s2_q.data),
			.trig_i(trg_s2_q[g]),
			.stat_o(ch_stat[g])
		);
	end

	// return-from-interrupt watch; last byte seen in a fetch is the opcode
	always_comb begin
		op_d = fetch ? pin_s2_q.data : op_q;
		prev_ed_d = prev_ed_q;
		return_from_irq_opcode_ev = 1'b0;
		if (fetch_end) begin
			return_from_irq_opcode_ev = prev_ed_q && (op_q == RETURN_FROM_IRQ_OPCODE_BYTE2);
			prev_ed_d = (op_q == RETURN_FROM_IRQ_OPCODE_BYTE1);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			op_q <= 8'h00;
			prev_ed_q <= 1'b0;
		end else begin
			op_q <= op_d;
			prev_ed_q <= prev_ed_d;
		end
	end

	// interrupt, vector and bus drive
	always_comb begin
		ip_d = ip_q;
		ius_d = ius_q;
		svc_d = svc_q;
		vec_d = vec_q;
		vec_drive_d = vec_drive_q;
		elig = eligible(ip_q, ius_q);
		if (wr_stb && !pin_s2_q.data[CW_CTRL] && !ch_stat[pin_s2_q.sel].tc_next) begin
			vec_d = pin_s2_q.data;
		end
		for (int i = 0; i < NUM_CH; i++) begin
			if (!ch_stat[i].ctrl[CW_IRQ_EN]) begin
				ip_d[i] = 1'b0;
			end
		end
		if (return_from_irq_opcode_ev && |ius_q) begin
			ius_d[first_set(ius_q)] = 1'b0;
		end
		if (ack_start) begin
			vec_drive_d = 1'b0;
			if (iei_s2_q && |elig) begin
				svc_d = first_set(elig);
				ius_d[first_set(elig)] = 1'b1;
				ip_d[first_set(elig)] = 1'b0;
				vec_drive_d = 1'b1;
			end
		end else if (!ack) begin
			vec_drive_d = 1'b0;
		end
		// a zero in the same cycle as the acknowledge clear still counts
		for (int i = 0; i < NUM_CH; i++) begin
			if (zero_vec[i] && ch_stat[i].ctrl[CW_IRQ_EN]) begin
				ip_d[i] = 1'b1;
			end
		end
		data_d = 8'h00;
		data_oe_d = 1'b0;
		if (vec_drive_d) begin
			data_d = {vec_q[7:3], svc_d, 1'b0};
			data_oe_d = 1'b1;
		end else if (io_rd) begin
			data_d = ch_stat[pin_s2_q.sel].cnt;
			data_oe_d = 1'b1;
		end
		irq_oe_d = iei_s2_q && |elig;
		chain_out_d = iei_s2_q && !(|ius_d);
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			ip_q <= '0;
			ius_q <= '0;
			svc_q <= 2'd0;
			vec_q <= VEC_RST;
			vec_drive_q <= 1'b0;
			data_o <= 8'h00;
			data_oe_o <= 1'b0;
			irq_oe_o <= 1'b0;
			zero_count_pulse_o <= '0;
		end else begin
			ip_q <= ip_d;
			ius_q <= ius_d;
			svc_q <= svc_d;
			vec_q <= vec_d;
			vec_drive_q <= vec_drive_d;
			data_o <= data_d;
			data_oe_o <= data_oe_d;
			irq_oe_o <= irq_oe_d;
			zero_count_pulse_o <= zero_vec[NUM_ZC-1:0];
		end
	end

	// open drain: only ever pulls low, chain out follows enable in while reset clears service
	always_ff @(posedge mclk_i) begin
		irq_b_o <= 1'b0;
		chain_enable_out_o <= chain_out_d;
	end

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);

	property p_vec_lsb;
		vec_drive_q |-> data_oe_o && !data_o[0];
	endproperty
	a_vec_lsb: assert property (p_vec_lsb) else $error("vector bit 0 not zero");

	property p_vec_fmt;
		vec_drive_q |-> data_o[7:3] == vec_q[7:3] && data_o[2:1] == svc_q;
	endproperty
	a_vec_fmt: assert property (p_vec_fmt) else $error("vector format wrong");

	property p_vec_gate;
		ack_start && !iei_s2_q |=> !vec_drive_q && !data_oe_o;
	endproperty
	a_vec_gate: assert property (p_vec_gate) else $error("vector driven without chain enable");

	property p_chain_block;
		|ius_d |=> !chain_enable_out_o;
	endproperty
	a_chain_block: assert property (p_chain_block) else $error("chain out high in service");

	property p_read;
		io_rd && !vec_drive_d |=> data_oe_o && data_o == $past(ch_stat[pin_s2_q.sel].cnt);
	endproperty
	a_read: assert property (p_read) else $error("read did not return counter");

	property p_irq;
		zero_vec[0] && ch_stat[0].ctrl[CW_IRQ_EN] && iei_s2_q && ius_q == 4'h0 ##1 iei_s2_q
			|=> irq_oe_o;
	endproperty
	a_irq: assert property (p_irq) else $error("no request after zero");

	property p_reload;
		zero_count_pulse_o[0] |-> $past(ch_stat[0].zero) && $past(ch_stat[0].cnt) == $past(ch_stat[0].tc);
	endproperty
	a_reload: assert property (p_reload) else $error("counter not reloaded at zero");

	property p_zc_pulse;
		zero_count_pulse_o[1] |=> !zero_count_pulse_o[1];
	endproperty
	a_zc_pulse: assert property (p_zc_pulse) else $error("zero pulse stuck");

	property p_return_from_irq_opcode;
		return_from_irq_opcode_ev && ius_q == 4'b0101 && !ack_start |=> ius_q == 4'b0100;
	endproperty
	a_return_from_irq_opcode: assert property (p_return_from_irq_opcode) else $error("return did not clear service");

	property p_prio;
		ack_start && iei_s2_q && ip_q[0] && !ius_q[0] |=> svc_q == 2'd0 && ius_q[0];
	endproperty
	a_prio: assert property (p_prio) else $error("priority order broken");

	property p_nest;
		ius_q == 4'b0100 && ip_q[0] && ch_stat[0].ctrl[CW_IRQ_EN] && iei_s2_q && !ack_start
			|=> irq_oe_o;
	endproperty
	a_nest: assert property (p_nest) else $error("higher priority blocked");

	c_ack: cover property (ack_start && iei_s2_q && |elig ##[1:20] vec_drive_q);
	c_return_from_irq_opcode: cover property (return_from_irq_opcode_ev && |ius_q);
	c_read: cover property (io_rd ##1 data_oe_o);
	c_zero: cover property (zero_count_pulse_o[2]);

endmodule

// file: hw/fcct_pkg.sv
package fcct_pkg;

	localparam int unsigned NUM_CH = 4;
	localparam int unsigned NUM_ZC = 3;

	// control word fields
	localparam int unsigned CW_IRQ_EN = 7;
	localparam int unsigned CW_MODE = 6;
	localparam int unsigned CW_PSC = 5;
	localparam int unsigned CW_EDGE = 4;
	localparam int unsigned CW_TRIG = 3;
	localparam int unsigned CW_TC = 2;
	localparam int unsigned CW_RST = 1;
	localparam int unsigned CW_CTRL = 0;

	// prescaler wrap masks, period 16 and 256 clocks
	localparam logic [7:0] PSC_MASK_16 = 8'h0f;
	localparam logic [7:0] PSC_MASK_256 = 8'hff;

	// return-from-interrupt opcode pair
	localparam logic [7:0] RETURN_FROM_IRQ_OPCODE_BYTE1 = 8'hed;
	localparam logic [7:0] RETURN_FROM_IRQ_OPCODE_BYTE2 = 8'h4d;

	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] TC_RST = 8'h00;
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [7:0] PSC_RST = 8'h00;
	localparam logic [7:0] VEC_RST = 8'h00;

	typedef enum logic [1:0] {CH_STOP, CH_ARMED, CH_RUN} fcct_ch_state_t;

	// host bus pins after synchronising
	typedef struct packed {
		logic iorq_b;
		logic rd_b;
		logic m1_b;
		logic ce_b;
		logic [1:0] sel;
		logic [7:0] data;
	} fcct_pins_t;

	// per-channel state seen by the top
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] tc;
		logic [7:0] cnt;
		logic tc_next;
		logic zero;
	} fcct_ch_stat_t;

endpackage

// file: hw/fcct_channel.sv
`timescale 1ns/1ps
module fcct_channel
	import fcct_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// host write for this channel
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	// synchronised trigger level
	input wire logic trig_i,
	// channel state
	output fcct_ch_stat_t stat_o
);

	fcct_ch_state_t st_q, st_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic [7:0] tc_q, tc_d;
	logic [7:0] cnt_q, cnt_d;
	logic [7:0] psc_q, psc_d;
	logic [7:0] mask;
	logic tc_next_q, tc_next_d;
	logic trig_q;
	logic zero_q, zero_d;
	logic edge_hit;
	logic tick;

	always_comb begin
		st_d = st_q;
		ctrl_d = ctrl_q;
		tc_d = tc_q;
		cnt_d = cnt_q;
		psc_d = psc_q;
		tc_next_d = tc_next_q;
		zero_d = 1'b0;
		tick = 1'b0;
		mask = ctrl_q[CW_PSC] ? PSC_MASK_256 : PSC_MASK_16;
		edge_hit = ctrl_q[CW_EDGE] ? (trig_i & ~trig_q) : (~trig_i & trig_q);
		unique case (st_q)
			CH_STOP: begin
				psc_d = PSC_RST;
			end
			CH_ARMED: begin
				psc_d = PSC_RST;
				if (edge_hit) begin
					st_d = CH_RUN;
				end
			end
			CH_RUN: begin
				if (ctrl_q[CW_MODE]) begin
					tick = edge_hit;
				end else begin
					psc_d = psc_q + 8'h01;
					tick = (psc_q & mask) == mask;
				end
			end
		endcase
		if (tick) begin
			// reload instead of showing zero; a zero constant wraps through 256 steps
			if (cnt_q == 8'h01) begin
				cnt_d = tc_q;
				zero_d = 1'b1;
			end else begin
				cnt_d = cnt_q - 8'h01;
			end
		end
		if (wr_i) begin
			if (tc_next_q) begin
				tc_d = wdata_i;
				tc_next_d = 1'b0;
				if (st_q == CH_STOP) begin
					cnt_d = wdata_i;
					psc_d = PSC_RST;
					st_d = (!ctrl_q[CW_MODE] && ctrl_q[CW_TRIG]) ? CH_ARMED : CH_RUN;
				end
			end else if (wdata_i[CW_CTRL]) begin
				ctrl_d = wdata_i;
				tc_next_d = wdata_i[CW_TC];
				if (wdata_i[CW_RST]) begin
					st_d = CH_STOP;
				end
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			st_q <= CH_STOP;
			ctrl_q <= CTRL_RST;
			tc_q <= TC_RST;
			cnt_q <= CNT_RST;
			psc_q <= PSC_RST;
			tc_next_q <= 1'b0;
			zero_q <= 1'b0;
			trig_q <= 1'b0;
		end else begin
			st_q <= st_d;
			ctrl_q <= ctrl_d;
			tc_q <= tc_d;
			cnt_q <= cnt_d;
			psc_q <= psc_d;
			tc_next_q <= tc_next_d;
			zero_q <= zero_d;
			trig_q <= trig_i;
		end
	end

	assign stat_o = '{ctrl: ctrl_q, tc: tc_q, cnt: cnt_q, tc_next: tc_next_q, zero: zero_q};

endmodule

// file: verif/fcct_host.sv
`timescale 1ns/1ps
module fcct_host (
	// clock
	input wire logic mclk_i,
	// device side of the bus
	input wire logic [7:0] data_o,
	input wire logic data_oe_o,
	input wire logic irq_b_o,
	input wire logic irq_oe_o,
	// host pins, ctl_o is {iorq_b, rd_b, m1_b, ce_b}
	output logic [3:0] ctl_o,
	output logic [1:0] sel_o,
	output logic [7:0] bus_o,
	output logic irq_n_o
);
	logic drv_q = 1'b0;
	logic [7:0] hd_q = 8'h00;
	logic [7:0] last_q = 8'h00;
	initial ctl_o = 4'hf;
	initial sel_o = 2'b00;
	// released bus flips every cycle so a stale byte never passes
	assign bus_o = data_oe_o ? data_o : (drv_q ? hd_q : ~last_q);
	// open-drain line with pull-up
	assign irq_n_o = irq_oe_o ? irq_b_o : 1'b1;
	always @(posedge mclk_i) last_q <= bus_o;
	// whole cycle held n edges, answer taken at the last held edge
	task automatic cyc(input logic [3:0] c, input logic [1:0] s, input logic drv,
		input logic [7:0] d, input int n, output logic [7:0] q);
		@(posedge mclk_i);
		ctl_o <= c;
		sel_o <= s;
		drv_q <= drv;
		hd_q <= d;
		repeat (n) @(posedge mclk_i);
		q = bus_o;
		ctl_o <= 4'hf;
		drv_q <= 1'b0;
		repeat (4) @(posedge mclk_i);
	endtask
	task automatic wr(input logic [1:0] s, input logic [7:0] d);
		logic [7:0] q;
		cyc(4'b0110, s, 1'b1, d, 4, q);
	endtask
	task automatic rd(input logic [1:0] s, output logic [7:0] q);
		cyc(4'b0010, s, 1'b0, 8'h00, 6, q);
	endtask
	// vectored acknowledge
	task automatic ack(output logic [7:0] q);
		cyc(4'b0101, 2'b00, 1'b0, 8'h00, 6, q);
	endtask
	task automatic return_from_irq_opcode();
		logic [7:0] q;
		cyc(4'b1001, 2'b00, 1'b1, 8'hed, 4, q);
		cyc(4'b1001, 2'b00, 1'b1, 8'h4d, 4, q);
	endtask
endmodule

// file: verif/fcct_top_test.sv
`timescale 1ns/1ps
module fcct_top_test;
	import fcct_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic chain_in = 1'b1;
	logic [3:0] trig = 4'h0;
	logic [3:0] ctl;
	logic [1:0] sel;
	logic [7:0] bus, dout, q, v, m, vec;
	logic oe, ceo, irq_b, irq_oe, irq_n;
	logic seen_oe = 1'b0;
	logic [2:0] zc;
	logic [7:0] tc [4];
	int k [4];
	int zc_n [3] = '{0, 0, 0};
	int n_errors = 0;
	int check_count = 0;
	always #4 mclk_i = ~mclk_i;
	fcct_host host (.mclk_i(mclk_i), .data_o(dout), .data_oe_o(oe), .irq_b_o(irq_b),
		.irq_oe_o(irq_oe), .ctl_o(ctl), .sel_o(sel), .bus_o(bus), .irq_n_o(irq_n));
	fcct_top DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .chip_en_b_i(ctl[0]),
		.iorq_b_i(ctl[3]), .rd_b_i(ctl[2]), .m1_b_i(ctl[1]), .chan_sel_lo_i(sel[0]),
		.chan_sel_hi_i(sel[1]), .data_i(bus), .data_o(dout), .data_oe_o(oe),
		.chain_enable_in_i(chain_in), .chain_enable_out_o(ceo), .irq_b_o(irq_b),
		.irq_oe_o(irq_oe), .ext_count_trigger_i(trig), .zero_count_pulse_o(zc));
	always @(posedge mclk_i) begin
		for (int i = 0; i < 3; i++) zc_n[i] += zc[i];
		if (oe) seen_oe <= 1'b1;
	end
	task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// counter value after n ticks from a fresh load
	function automatic logic [7:0] exp_cnt(input logic [7:0] t, input int n);
		int p;
		p = (t == 8'h00) ? 256 : int'(t);
		return 8'(p - n % p);
	endfunction
	task automatic prog(input logic [1:0] c, input logic [7:0] w, input logic [7:0] t);
		host.wr(c, w);
		host.wr(c, t);
	endtask
	// each pass gives one edge; two passes give one rising and one falling edge
	task automatic pulses(input logic [3:0] msk, input int n);
		repeat (2 * n) begin
			@(posedge mclk_i);
			trig <= trig ^ msk;
			repeat (3) @(posedge mclk_i);
		end
		repeat (4) @(posedge mclk_i);
	endtask
	initial begin
		#400000;
		n_errors++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'h24f0868c));
		repeat (19) @(posedge mclk_i);
		check("reset pins", {2'b0, oe, irq_n, zc, ceo}, {5'b00010, 2'b0, chain_in});
		@(posedge mclk_i) rst_b_i <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			tc[c] = (c == 3) ? 8'h00 : 8'($urandom_range(9, 2));
			k[c] = $urandom_range(20, 1);
			prog(2'(c), {3'b010, 1'($urandom_range(1, 0)), 4'b0101}, tc[c]);
		end
		for (int c = 0; c < 4; c++) pulses(4'(1 << c), k[c]);
		for (int c = 0; c < 4; c++) begin
			host.rd(2'(c), q);
			check("count", q, exp_cnt(tc[c], k[c]));
			if (c < 3) check("zero pulses", 8'(zc_n[c]), 8'(k[c] / int'(tc[c])));
		end
		v = exp_cnt(tc[1], k[1]);
		m = 8'($urandom_range(9, 2));
		prog(2'd1, 8'h55, m);
		host.rd(2'd1, q);
		check("count kept", q, v);
		pulses(4'h2, int'(v));
		host.rd(2'd1, q);
		check("new constant", q, m);
		$display("test counter done");
		for (int s = 0; s < 2; s++) begin
			prog(2'd2, s ? 8'h27 : 8'h07, 8'h00);
			host.rd(2'd2, v);
			repeat (s ? 2549 : 149) @(posedge mclk_i);
			host.rd(2'd2, q);
			check("prescale", v - q, 8'h0a);
		end
		prog(2'd2, 8'h0f, 8'h00);
		repeat (100) @(posedge mclk_i);
		host.rd(2'd2, q);
		check("trigger wait", q, 8'h00);
		pulses(4'h4, 1);
		repeat (100) @(posedge mclk_i);
		host.rd(2'd2, q);
		check("trigger start", {7'h0, q != 8'h00}, 8'h01);
		$display("test timer done");
		vec = 8'($urandom) & 8'hf8;
		host.wr(2'd0, vec);
		prog(2'd2, 8'hd7, 8'h01);
		prog(2'd3, 8'hd7, 8'h01);
		pulses(4'hc, 1);
		check("irq", {7'h0, irq_n}, 8'h00);
		host.ack(q);
		check("vector ch2", q, {vec[7:3], 3'b100});
		check("chain out busy", {7'h0, ceo}, 8'h00);
		check("irq blocked", {7'h0, irq_n}, 8'h01);
		prog(2'd0, 8'hd7, 8'h01);
		pulses(4'h1, 1);
		check("irq nested", {7'h0, irq_n}, 8'h00);
		host.ack(q);
		check("vector ch0", q, {vec[7:3], 3'b000});
		host.return_from_irq_opcode();
		check("chain out nested", {7'h0, ceo}, 8'h00);
		host.return_from_irq_opcode();
		check("chain out free", {7'h0, ceo}, 8'h01);
		// request follows the cleared service one edge later
		repeat (2) @(negedge mclk_i);
		check("irq ch3", {7'h0, irq_n}, 8'h00);
		@(posedge mclk_i) chain_in <= 1'b0;
		repeat (6) @(posedge mclk_i);
		check("chain out gated", {7'h0, ceo}, 8'h00);
		seen_oe = 1'b0;
		host.ack(q);
		check("vector gated", {7'h0, seen_oe}, 8'h00);
		@(posedge mclk_i) chain_in <= 1'b1;
		repeat (6) @(posedge mclk_i);
		host.ack(q);
		check("vector ch3", q, {vec[7:3], 3'b110});
		host.return_from_irq_opcode();
		check("chain out end", {7'h0, ceo}, 8'h01);
		$display("test interrupt done");
		end_of_test();
	end
endmodule
